/* inc/lpsm_map.svh */
// register offsets, field positions, reset values and timing of the monitor
`ifndef LPSM_MAP_SVH
`define LPSM_MAP_SVH
// register byte offsets on the plain port
`define LPSM_OFF_MODE 8'h00
`define LPSM_OFF_PERIOD 8'h04
`define LPSM_OFF_PHSTAT 8'h08
`define LPSM_OFF_THR 8'h0c
`define LPSM_OFF_STATUS 8'h10
`define LPSM_OFF_DIPCYC 8'h14
`define LPSM_OFF_ENABLE 8'h18
`define LPSM_OFF_IMAX 8'h1c
`define LPSM_OFF_VMAX 8'h20
`define LPSM_OFF_PKCYC 8'h24
// field positions
`define LPSM_MODE_PSEL_LO 0
`define LPSM_MODE_PKSEL_LO 2
`define LPSM_BIT_DIP 16
`define LPSM_BIT_IDONE 23
`define LPSM_BIT_VDONE 24
`define LPSM_PH_DIP_LO 12
`define LPSM_MAX_PH_LO 24
// reset values
`define LPSM_RST_MODE 8'h1c
`define LPSM_RST_THR 24'h000000
`define LPSM_RST_DIPCYC 8'h10
`define LPSM_RST_PKCYC 8'h00
`define LPSM_RST_ENABLE 32'h00000000
// status bits that exist
`define LPSM_STATUS_IMPL 32'h01810000
// level limits
`define LPSM_FULL_SCALE 24'h5a7540
`define LPSM_ZX_MIN_LVL 24'h090bba
// clock and period tick rates in kHz, tick period 3.90625 us
`define LPSM_CLK_KHZ 40000
`define LPSM_TICK_KHZ 256
`endif

/* inc/lpsm_pkg.sv */
// types and shared arithmetic of the line period / dip / max monitor
package lpsm_pkg;
    typedef logic [23:0] lpsm_mag_t;
    typedef logic signed [23:0] lpsm_smp_t;
    typedef logic [2:0] lpsm_phase_t;

    // magnitude of a signed sample, most negative code saturates
    function automatic lpsm_mag_t lpsm_abs(input lpsm_smp_t s);
        lpsm_mag_t m;
        m = s[23] ? lpsm_mag_t'(-s) : lpsm_mag_t'(s);
        if (s == 24'sh800000) begin
            m = 24'h7fffff;
        end
        return m;
    endfunction
endpackage

/* design/lpsm_zx.sv */
// zero-crossing detector for one channel with small-signal gate
`timescale 1ns/10ps
`default_nettype none
`include "lpsm_map.svh"
module lpsm_zx import lpsm_pkg::*; #(
    parameter bit IS_VOLT = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // sample stream
    input wire logic samp_valid,
    input wire lpsm_smp_t samp,
    // crossing pulse
    output logic zx
);
    logic sign_reg;
    logic seen_reg;
    lpsm_mag_t hpk_reg;
    lpsm_mag_t mag;

    assign mag = lpsm_abs(samp);

    // gate on half-cycle peak
    // voltage crossings need the last half cycle above a tenth of scale
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sign_reg <= 1'b0;
            seen_reg <= 1'b0;
            hpk_reg <= 24'h000000;
            zx <= 1'b0;
        end else begin
            zx <= 1'b0;
            if (samp_valid) begin
                seen_reg <= 1'b1;
                sign_reg <= samp[23];
                if (seen_reg && samp[23] != sign_reg) begin
                    zx <= !IS_VOLT || hpk_reg >= `LPSM_ZX_MIN_LVL;
                    hpk_reg <= mag;
                end else if (mag > hpk_reg) begin
                    hpk_reg <= mag;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* design/lpsm_period.sv */
// line period counter in 256 kHz ticks over two half cycles
`timescale 1ns/10ps
`default_nettype none
module lpsm_period (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // time base and crossings of the chosen phase
    input wire logic tick,
    input wire logic zx,
    // result
    output logic [15:0] period_val
);
    logic [15:0] cnt_reg;
    logic half_reg;

    // refresh once per line period
    // every second crossing closes a full period; the count saturates
    // so a very slow line shows the top code instead of wrapping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 16'h0000;
            half_reg <= 1'b0;
            period_val <= 16'h0000;
        end else begin
            if (zx) begin
                half_reg <= !half_reg;
            end
            // no filter, count jitters one tick at most
            if (zx && half_reg) begin
                period_val <= cnt_reg;
                cnt_reg <= {15'h0000, tick};
            end else if (tick && cnt_reg != 16'hffff) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* design/lpsm_top.sv */
// line period, voltage dip and max-level monitor with register port
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "lpsm_map.svh"
// Contract
// - period measured on the phase chosen by mode bits 1:0
// - period result is 16 bits unsigned, refreshed every line period
// - period counts 256 kHz ticks, 3.90625 us each
// - steady line gives period results within one count
// - dip flag bit 16 set after N consecutive low half cycles
// - dip sets its phase bit 14:12, clearing an earlier phase bit
// - writing one to bit 16 clears dip flag and phase bits
// - enabled dip drives interrupt low in the cycle flag sets
// - dip counter always runs; count write with threshold set restarts it
// - threshold vs magnitude; full scale always dips, 0 or 1 never
// - threshold reads as 32 bits with upper 8 zero
// - track max voltage and current magnitude per window, low 24 bits
// - max tracking only on phases enabled by mode bits 4:2
// - window counts crossings of every enabled phase
// - each nonzero max result carries exactly one phase bit 26:24
// - max value and phase change only at window end
// - window end sets status bits 23 and 24
// - enabled window-end bits drive interrupt low with status
// - writing one to a max status bit clears it, frees pin
// - window count write with phases enabled restarts the window
// - small voltages give no crossings, currents always do
module lpsm_top import lpsm_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // high-pass filtered samples
    input wire logic samp_valid,
    input wire lpsm_smp_t volt_a,
    input wire lpsm_smp_t volt_b,
    input wire lpsm_smp_t volt_c,
    input wire lpsm_smp_t curr_a,
    input wire lpsm_smp_t curr_b,
    input wire lpsm_smp_t curr_c,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt
    output logic event_irq_n
);
    logic rst_meta_reg;
    logic rst_n;
    lpsm_smp_t smp [6];
    logic [5:0] zx;
    logic [15:0] tick_acc_reg;
    logic tick;
    logic [15:0] period_val;
    logic [7:0] mode_reg;
    lpsm_mag_t thr_reg;
    logic [7:0] dipcyc_reg;
    logic [7:0] pkcyc_reg;
    logic [31:0] en_reg;
    logic [31:0] status_reg;
    logic [31:0] status_next;
    logic [31:0] status_set;
    logic [31:0] status_clr;
    lpsm_phase_t dip_phase_reg;
    lpsm_phase_t dip_hit;
    logic dip_set;
    logic dip_restart;
    logic [2:0] below;
    logic [2:0] below_reg;
    logic [7:0] dcnt_reg [3];
    logic [2:0] pk_en;
    logic pk_zx;
    logic pk_end;
    logic pk_restart;
    logic [7:0] pkcnt_reg;
    lpsm_mag_t vacc_reg;
    lpsm_mag_t iacc_reg;
    lpsm_phase_t vacc_ph_reg;
    lpsm_phase_t iacc_ph_reg;
    lpsm_mag_t vmax_reg;
    lpsm_mag_t imax_reg;
    lpsm_phase_t vph_reg;
    lpsm_phase_t iph_reg;
    lpsm_mag_t vcand;
    lpsm_mag_t icand;
    lpsm_phase_t vcand_ph;
    lpsm_phase_t icand_ph;

    // write strobe aimed at one register
    function automatic logic wr_at(input logic [7:0] off);
        return reg_wr && reg_addr == off;
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    assign smp[0] = volt_a;
    assign smp[1] = volt_b;
    assign smp[2] = volt_c;
    assign smp[3] = curr_a;
    assign smp[4] = curr_b;
    assign smp[5] = curr_c;

    // crossing detectors, first three are voltages
    for (genvar g = 0; g < 6; g++) begin : g_zx
        lpsm_zx #(.IS_VOLT(g < 3)) u_zx (
            .clk(ref_clk),
            .rst_n(rst_n),
            .samp_valid(samp_valid),
            .samp(smp[g]),
            .zx(zx[g])
        );
    end

    // fractional divider to 256 kHz
    // 40 MHz is not a whole multiple, so the phase accumulator keeps the
    // average rate exact at the cost of one clock of tick jitter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_acc_reg <= 16'h0000;
        end else if (tick) begin
            tick_acc_reg <= tick_acc_reg + 16'(`LPSM_TICK_KHZ)
                - 16'(`LPSM_CLK_KHZ);
        end else begin
            tick_acc_reg <= tick_acc_reg + 16'(`LPSM_TICK_KHZ);
        end
    end
    assign tick = tick_acc_reg + 16'(`LPSM_TICK_KHZ) >= 16'(`LPSM_CLK_KHZ);

    // selected voltage crossing, code 3 falls back to phase a
    lpsm_period u_period (
        .clk(ref_clk),
        .rst_n(rst_n),
        .tick(tick),
        .zx(mode_reg[1:0] == 2'h3 ? zx[0] : zx[mode_reg[1:0]]),
        .period_val(period_val)
    );

    // configuration registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= `LPSM_RST_MODE;
            thr_reg <= `LPSM_RST_THR;
            dipcyc_reg <= `LPSM_RST_DIPCYC;
            pkcyc_reg <= `LPSM_RST_PKCYC;
            en_reg <= `LPSM_RST_ENABLE;
        end else begin
            if (wr_at(`LPSM_OFF_MODE)) mode_reg <= reg_wdata[7:0];
            if (wr_at(`LPSM_OFF_THR)) thr_reg <= reg_wdata[23:0];
            if (wr_at(`LPSM_OFF_DIPCYC)) dipcyc_reg <= reg_wdata[7:0];
            if (wr_at(`LPSM_OFF_PKCYC)) pkcyc_reg <= reg_wdata[7:0];
            if (wr_at(`LPSM_OFF_ENABLE)) en_reg <= reg_wdata;
        end
    end

    // low-level compare, thresholds 0 and 1 never qualify
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            below[p] = thr_reg > 24'h000001 && lpsm_abs(smp[p]) <= thr_reg;
        end
    end

    // dip restart on count write once threshold set
    assign dip_restart = wr_at(`LPSM_OFF_DIPCYC) && thr_reg != 24'h000000;

    // half cycle closes at a crossing, all samples must be low
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            dip_hit[p] = zx[p] && below_reg[p]
                && dcnt_reg[p] + 8'h01 == dipcyc_reg;
        end
    end
    assign dip_set = |dip_hit;

    // per-phase consecutive low half-cycle counters, always running
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            below_reg <= 3'h7;
            for (int p = 0; p < 3; p++) dcnt_reg[p] <= 8'h00;
        end else begin
            for (int p = 0; p < 3; p++) begin
                if (dip_restart) begin
                    below_reg[p] <= 1'b1;
                    dcnt_reg[p] <= 8'h00;
                end else if (zx[p]) begin
                    below_reg[p] <= 1'b1;
                    if (dip_hit[p] || !below_reg[p]) begin
                        dcnt_reg[p] <= 8'h00;
                    end else begin
                        dcnt_reg[p] <= dcnt_reg[p] + 8'h01;
                    end
                end else if (samp_valid && !below[p]) begin
                    below_reg[p] <= 1'b0;
                end
            end
        end
    end

    // window advances on crossings of every enabled phase
    assign pk_en = mode_reg[`LPSM_MODE_PKSEL_LO +: 3];
    assign pk_zx = |(zx[2:0] & pk_en);
    assign pk_end = pk_zx && pkcyc_reg != 8'h00
        && pkcnt_reg + 8'h01 >= pkcyc_reg;
    // window restart on count write with phases enabled
    assign pk_restart = wr_at(`LPSM_OFF_PKCYC) && pk_en != 3'h0;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pkcnt_reg <= 8'h00;
        end else if (pk_restart || pk_end) begin
            pkcnt_reg <= 8'h00;
        end else if (pk_zx) begin
            pkcnt_reg <= pkcnt_reg + 8'h01;
        end
    end

    // largest enabled magnitude of this sample, lowest phase wins ties
    always_comb begin
        vcand = 24'h000000;
        icand = 24'h000000;
        vcand_ph = 3'h0;
        icand_ph = 3'h0;
        for (int p = 0; p < 3; p++) begin
            if (pk_en[p] && lpsm_abs(smp[p]) > vcand) begin
                vcand = lpsm_abs(smp[p]);
                vcand_ph = lpsm_phase_t'(3'h1 << p);
            end
            if (pk_en[p] && lpsm_abs(smp[p + 3]) > icand) begin
                icand = lpsm_abs(smp[p + 3]);
                icand_ph = lpsm_phase_t'(3'h1 << p);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vacc_reg <= 24'h000000;
            iacc_reg <= 24'h000000;
            vacc_ph_reg <= 3'h0;
            iacc_ph_reg <= 3'h0;
        end else if (pk_restart || pk_end) begin
            vacc_reg <= 24'h000000;
            iacc_reg <= 24'h000000;
            vacc_ph_reg <= 3'h0;
            iacc_ph_reg <= 3'h0;
        end else if (samp_valid) begin
            if (vcand > vacc_reg) begin
                vacc_reg <= vcand;
                vacc_ph_reg <= vcand_ph;
            end
            if (icand > iacc_reg) begin
                iacc_reg <= icand;
                iacc_ph_reg <= icand_ph;
            end
        end
    end

    // results move only at window end
    // phase field is replaced whole, so the old bit drops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            vmax_reg <= 24'h000000;
            imax_reg <= 24'h000000;
            vph_reg <= 3'h0;
            iph_reg <= 3'h0;
        end else if (pk_end) begin
            vmax_reg <= vacc_reg;
            imax_reg <= iacc_reg;
            vph_reg <= vacc_ph_reg;
            iph_reg <= iacc_ph_reg;
        end
    end

    // window end and dip raise their status bits
    always_comb begin
        status_set = 32'h00000000;
        status_set[`LPSM_BIT_DIP] = dip_set;
        status_set[`LPSM_BIT_IDONE] = pk_end;
        status_set[`LPSM_BIT_VDONE] = pk_end;
    end
    // only ones written clear, a set in the same cycle wins
    assign status_clr = wr_at(`LPSM_OFF_STATUS) ? reg_wdata : 32'h00000000;
    assign status_next = ((status_reg & ~status_clr) | status_set)
        & `LPSM_STATUS_IMPL;

    // one written to a max status bit clears it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 32'h00000000;
        end else begin
            status_reg <= status_next;
        end
    end

    // newest dip phase replaces the earlier one
    // clearing the dip flag also clears the phase bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dip_phase_reg <= 3'h0;
        end else if (dip_set) begin
            dip_phase_reg <= dip_hit[0] ? 3'h1 : dip_hit[1] ? 3'h2 : 3'h4;
        end else if (status_clr[`LPSM_BIT_DIP]) begin
            dip_phase_reg <= 3'h0;
        end
    end

    // pin follows status and enable with no extra delay
    // window-end bits share the same pin
    assign event_irq_n = ~|(status_reg & en_reg & `LPSM_STATUS_IMPL);

    // read data one cycle later, unused high bits zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `LPSM_OFF_MODE: reg_rdata <= {24'h000000, mode_reg};
                `LPSM_OFF_PERIOD: reg_rdata <= {16'h0000, period_val};
                `LPSM_OFF_PHSTAT: reg_rdata <= {17'h00000, dip_phase_reg,
                    12'h000};
                `LPSM_OFF_THR: reg_rdata <= {8'h00, thr_reg};
                `LPSM_OFF_STATUS: reg_rdata <= status_reg;
                `LPSM_OFF_DIPCYC: reg_rdata <= {24'h000000, dipcyc_reg};
                `LPSM_OFF_ENABLE: reg_rdata <= en_reg;
                `LPSM_OFF_IMAX: reg_rdata <= {5'h00, iph_reg, imax_reg};
                `LPSM_OFF_VMAX: reg_rdata <= {5'h00, vph_reg, vmax_reg};
                `LPSM_OFF_PKCYC: reg_rdata <= {24'h000000, pkcyc_reg};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
    end

    // checks guarding the status, pin and result behaviour
    sequence s_dip_clr;
        wr_at(`LPSM_OFF_STATUS) && reg_wdata[`LPSM_BIT_DIP] && !dip_set;
    endsequence
    sequence s_dip_gone;
        !status_reg[`LPSM_BIT_DIP] && dip_phase_reg == 3'h0;
    endsequence

    property p_dip_clear;
        @(posedge ref_clk) disable iff (!rst_n) s_dip_clr |=> s_dip_gone;
    endproperty
    a_dip_clear: assert property (p_dip_clear)
        else $error("dip flag or phase survived a clear");

    property p_dip_irq;
        @(posedge ref_clk) disable iff (!rst_n)
        dip_set && en_reg[`LPSM_BIT_DIP] |=> !event_irq_n
            && status_reg[`LPSM_BIT_DIP];
    endproperty
    a_dip_irq: assert property (p_dip_irq)
        else $error("enabled dip did not pull the pin low");

    property p_dip_phase;
        @(posedge ref_clk) disable iff (!rst_n)
        dip_set |=> $onehot(dip_phase_reg)
            && (dip_phase_reg & $past(dip_hit)) != 3'h0;
    endproperty
    a_dip_phase: assert property (p_dip_phase)
        else $error("dip phase bit not the causing phase");

    property p_keep_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_at(`LPSM_OFF_STATUS) && !reg_wdata[`LPSM_BIT_VDONE]
            && status_reg[`LPSM_BIT_VDONE] |=> status_reg[`LPSM_BIT_VDONE];
    endproperty
    a_keep_zero: assert property (p_keep_zero)
        else $error("zero written cleared a status bit");

    property p_max_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        !pk_end |=> $stable(vmax_reg) && $stable(imax_reg)
            && $stable(iph_reg) && $stable(vph_reg);
    endproperty
    a_max_hold: assert property (p_max_hold)
        else $error("max result moved inside a window");

    property p_win_done;
        @(posedge ref_clk) disable iff (!rst_n)
        pk_end |=> status_reg[`LPSM_BIT_IDONE] && status_reg[`LPSM_BIT_VDONE]
            && (vmax_reg == 24'h000000 || $onehot(vph_reg))
            && (imax_reg == 24'h000000 || $onehot(iph_reg));
    endproperty
    a_win_done: assert property (p_win_done)
        else $error("window end status or phase field wrong");

    property p_pin_high;
        @(posedge ref_clk) disable iff (!rst_n)
        (status_reg & en_reg) == 32'h00000000 |-> event_irq_n;
    endproperty
    a_pin_high: assert property (p_pin_high)
        else $error("pin low with nothing enabled pending");

    property p_thr_read;
        @(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == `LPSM_OFF_THR |=>
            reg_rdata == {8'h00, $past(thr_reg)};
    endproperty
    a_thr_read: assert property (p_thr_read)
        else $error("threshold read back wrong or padded");

    property p_dip_restart;
        @(posedge ref_clk) disable iff (!rst_n)
        dip_restart |=> dcnt_reg[0] == 8'h00 && dcnt_reg[1] == 8'h00
            && dcnt_reg[2] == 8'h00;
    endproperty
    a_dip_restart: assert property (p_dip_restart)
        else $error("dip counters not restarted by count write");
endmodule
`default_nettype wire

/* tb/lpsm_top_bench.sv */
// self-checking bench for the line period, dip and max monitor
`timescale 1ns/10ps
`default_nettype none
`include "lpsm_map.svh"
module lpsm_top_bench import lpsm_pkg::*;;
    // SPH samples per half cycle, one every gap clocks
    localparam int SPH = 40;
    localparam int GAP = 25;
    localparam int PER = 2 * SPH * GAP * `LPSM_TICK_KHZ / `LPSM_CLK_KHZ;
    // period at half the line rate, gap doubled
    localparam int PER2 = 4 * SPH * GAP * `LPSM_TICK_KHZ / `LPSM_CLK_KHZ;
    int gap = GAP;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic samp_valid = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic event_irq_n;
    logic pol = 1'b0;
    lpsm_smp_t va [3];
    lpsm_smp_t ia [3];
    lpsm_smp_t vs [3];
    lpsm_smp_t cs [3];
    logic [31:0] rv;
    logic [31:0] p0;
    int n_mismatch = 0;
    int tests_run = 0;

    // 40 MHz reference clock
    always #12.5 ref_clk = ~ref_clk;

    lpsm_top dut (.ref_clk(ref_clk), .nrst(nrst), .samp_valid(samp_valid),
        .volt_a(vs[0]), .volt_b(vs[1]), .volt_c(vs[2]), .curr_a(cs[0]),
        .curr_b(cs[1]), .curr_c(cs[2]), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .event_irq_n(event_irq_n));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // data stands from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk($sformatf("reg_%h", a), exp, d);
    endtask

    // square waves: every half boundary is a crossing on each current with nonzero amplitude and each voltage above a tenth of scale
    task automatic halves(input int n);
        for (int h = 0; h < n; h++) begin
            pol = ~pol;
            for (int s = 0; s < SPH; s++) begin
                repeat (gap - 1) @(posedge ref_clk);
                samp_valid <= 1'b1;
                for (int k = 0; k < 3; k++) begin
                    vs[k] <= pol ? -va[k] : va[k];
                    cs[k] <= pol ? -ia[k] : ia[k];
                end
                @(posedge ref_clk);
                samp_valid <= 1'b0;
            end
        end
    endtask

    // watchdog: the sequence needs about 57k cycles
    initial begin
        #(80000 * 25);
        n_mismatch++;
        give_verdict();
    end

    // main sequence
    initial begin
        for (int k = 0; k < 3; k++) begin
            va[k] = 24'h400000;
            ia[k] = 24'h000000;
            vs[k] = 24'h000000;
            cs[k] = 24'h000000;
        end
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        // reset values and an unmapped place
        rc(`LPSM_OFF_MODE, 32'(`LPSM_RST_MODE));
        rc(`LPSM_OFF_DIPCYC, 32'(`LPSM_RST_DIPCYC));
        rc(`LPSM_OFF_PKCYC, 32'(`LPSM_RST_PKCYC));
        rc(`LPSM_OFF_ENABLE, `LPSM_RST_ENABLE);
        rc(`LPSM_OFF_STATUS, 32'h0);
        rc(8'h28, 32'h0);
        wr(`LPSM_OFF_THR, 32'hffffffff);
        rc(`LPSM_OFF_THR, 32'h00ffffff);
        wr(`LPSM_OFF_THR, 32'h0);
        // period on phase A after settling, then on B with A silent
        halves(6);
        rd(`LPSM_OFF_PERIOD, p0);
        halves(2);
        rd(`LPSM_OFF_PERIOD, rv);
        chk("period", 1, 32'(rv >= PER && rv <= PER + 1));
        chk("period_step", 1, 32'(rv - p0 + 1 <= 2));
        wr(`LPSM_OFF_MODE, 32'h1d);
        va[0] = 24'h000000;
        halves(4);
        rd(`LPSM_OFF_PERIOD, rv);
        chk("period_b", 1, 32'(rv >= PER && rv <= PER + 1));
        // phase C at half the rate, so a stale result cannot pass
        va[1] = 24'h000000;
        gap = 2 * GAP;
        wr(`LPSM_OFF_MODE, 32'h1e);
        halves(4);
        rd(`LPSM_OFF_PERIOD, rv);
        chk("period_c", 1, 32'(rv >= PER2 && rv <= PER2 + 1));
        // code 3 falls back to phase A, C silent
        gap = GAP;
        va[0] = 24'h400000;
        va[1] = 24'h400000;
        va[2] = 24'h000000;
        wr(`LPSM_OFF_MODE, 32'h1f);
        halves(5);
        rd(`LPSM_OFF_PERIOD, rv);
        chk("period_a3", 1, 32'(rv >= PER && rv <= PER + 1));
        va[2] = 24'h400000;
        // phase A dips; a count write restarts the half-cycle count
        wr(`LPSM_OFF_THR, 32'h00200000);
        wr(`LPSM_OFF_ENABLE, 32'h00010000);
        wr(`LPSM_OFF_DIPCYC, 32'h4);
        va[0] = 24'h100000;
        halves(3);
        wr(`LPSM_OFF_DIPCYC, 32'h4);
        halves(2);
        rc(`LPSM_OFF_STATUS, 32'h0);
        halves(2);
        rc(`LPSM_OFF_STATUS, 32'h00010000);
        rc(`LPSM_OFF_PHSTAT, 32'h00001000);
        chk("irq_dip", 0, 32'(event_irq_n));
        wr(`LPSM_OFF_STATUS, 32'h0);
        va[0] = 24'h400000;
        va[1] = 24'h100000;
        halves(6);
        rc(`LPSM_OFF_STATUS, 32'h00010000);
        rc(`LPSM_OFF_PHSTAT, 32'h00002000);
        va[1] = 24'h400000;
        wr(`LPSM_OFF_STATUS, 32'h00010000);
        rc(`LPSM_OFF_STATUS, 32'h0);
        rc(`LPSM_OFF_PHSTAT, 32'h0);
        chk("irq_clr", 1, 32'(event_irq_n));
        // threshold of one never dips, full scale always does
        wr(`LPSM_OFF_THR, 32'h1);
        va[0] = 24'h0a0000;
        halves(5);
        rc(`LPSM_OFF_STATUS, 32'h0);
        wr(`LPSM_OFF_THR, 32'(`LPSM_FULL_SCALE));
        wr(`LPSM_OFF_DIPCYC, 32'h1);
        halves(2);
        rc(`LPSM_OFF_STATUS, 32'h00010000);
        wr(`LPSM_OFF_THR, 32'h1);
        wr(`LPSM_OFF_STATUS, 32'h00010000);
        // max on phase A only, disabled B and C carry larger values
        ia[0] = 24'h123456;
        ia[1] = 24'h300000;
        ia[2] = 24'h500000;
        va[0] = 24'h250000;
        wr(`LPSM_OFF_MODE, 32'h04);
        wr(`LPSM_OFF_ENABLE, 32'h00800000);
        wr(`LPSM_OFF_PKCYC, 32'h2);
        halves(4);
        // status first, then the result registers
        rc(`LPSM_OFF_STATUS, 32'h01800000);
        rc(`LPSM_OFF_IMAX, 32'h01123456);
        rc(`LPSM_OFF_VMAX, 32'h01250000);
        chk("irq_max", 0, 32'(event_irq_n));
        // a larger value mid-window must not show until the window ends
        ia[0] = 24'h200000;
        halves(1);
        rc(`LPSM_OFF_IMAX, 32'h01123456);
        wr(`LPSM_OFF_STATUS, 32'h00800000);
        rc(`LPSM_OFF_STATUS, 32'h01000000);
        chk("irq_max_clr", 1, 32'(event_irq_n));
        halves(1);
        rc(`LPSM_OFF_IMAX, 32'h01200000);
        // phase B alone moves the phase bit
        wr(`LPSM_OFF_MODE, 32'h08);
        halves(4);
        rc(`LPSM_OFF_IMAX, 32'h02300000);
        rc(`LPSM_OFF_VMAX, 32'h02400000);
        // a voltage under a tenth of scale stops crossing, window stalls
        wr(`LPSM_OFF_STATUS, 32'h01800000);
        va[0] = 24'h080000;
        wr(`LPSM_OFF_MODE, 32'h04);
        halves(2);
        rc(`LPSM_OFF_STATUS, 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
